/* File: include/safe_stop_params.svh */
`ifndef SAFE_STOP_PARAMS_SVH
`define SAFE_STOP_PARAMS_SVH
// clock rate in kHz (250 MHz)
`define CLK_KHZ 250000
// glitch filter: off pulses of 0.5 ms or less are ignored, time in microseconds
`define GLITCH_TIME_US 500
`define GLITCH_CYCLES ((`GLITCH_TIME_US * `CLK_KHZ) / 1000 + 1)
// single channel timeout, 10 s in milliseconds
`define SKEW_TIME_MS 10000
`define SKEW_CYCLES (`SKEW_TIME_MS * `CLK_KHZ)
// feedback update bound, 20 ms in milliseconds
`define FEEDBACK_TIME_MS 20
`define FEEDBACK_CYCLES (`FEEDBACK_TIME_MS * `CLK_KHZ)
// operator display codes
`define DISP_RUN 2'h0
`define DISP_HARD_STOP 2'h1
`define DISP_ALARM 2'h2
// monitor value bit positions
`define MON_BIT_A 0
`define MON_BIT_B 1
`endif

/* File: include/safe_stop_pkg.sv */
package safe_stop_pkg;
   typedef struct packed {
      logic fault;
      logic [2:0] code;
   } fault_s;
   typedef enum logic [1:0] {
      disp_run,
      disp_hard_stop,
      disp_alarm
   } disp_e;
endpackage : safe_stop_pkg

/* File: rtl/stop_input_filter.sv */
`include "safe_stop_params.svh"
module stop_input_filter
   import safe_stop_pkg::*;
#(
   parameter int unsigned GLITCH_CYCLES = `GLITCH_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // raw stop request line, high means on
   input wire logic raw_in,
   // filtered state, high means on
   output logic filt_out
);
   localparam int CW = $clog2(GLITCH_CYCLES + 1);
   logic s1_reg, s1_next;
   logic s2_reg, s2_next;
   logic filt_reg, filt_next;
   logic [CW-1:0] cnt_reg, cnt_next;

   always_comb begin
      s1_next = raw_in;
      s2_next = s1_reg;
      filt_next = filt_reg;
      cnt_next = '0;
      // [RULE10] reject short offs
      if (s2_reg == filt_reg) begin
         cnt_next = '0;
      end else if (s2_reg) begin
         // going back on is taken at once
         filt_next = 1'b1;
      end else if (cnt_reg >= CW'(GLITCH_CYCLES - 1)) begin
         filt_next = 1'b0;
      end else begin
         cnt_next = cnt_reg + CW'(1);
      end
   end

   // [RULE12] synchronise and reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         filt_reg <= 1'b0;
         cnt_reg <= '0;
      end else begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         filt_reg <= filt_next;
         cnt_reg <= cnt_next;
      end
   end

   assign filt_out = filt_reg;
endmodule : stop_input_filter

/* File: rtl/safe_stop_feedback_monitor.sv */
`include "safe_stop_params.svh"
// Function
// [RULE1] While baseblocked, fault output and all fault code bits stay inactive.
// [RULE2] Feedback is on only when both stop request inputs are off.
// [RULE3] Feedback follows any input change within 20 ms.
// [RULE4] Both inputs off: show hard-stop code and keep motor disabled.
// [RULE5] Monitor bit 0 and bit 1 report input a and b on/off.
// [RULE6] Safety unit resets, restoring inputs, only after seeing feedback on.
// [RULE7] Feedback off with a stuck input; safety unit refuses reset.
// [RULE8] Outside equipment checks feedback failure status, e.g. at power-up.
// [RULE9] Either input off enters the hardwired baseblock state.
// [RULE10] Off pulses of 0.5 ms or less are ignored.
// [RULE11] One input off, other not following in 10 s: timing alarm.
// [RULE12] Inputs synchronised before use; all outputs cleared on reset.
module safe_stop_feedback_monitor
   import safe_stop_pkg::*;
#(
   parameter int unsigned GLITCH_CYCLES = `GLITCH_CYCLES,
   parameter longint unsigned SKEW_CYCLES = `SKEW_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // redundant stop requests, high means on (current flowing)
   input wire logic safe_stop_req_a,
   input wire logic safe_stop_req_b,
   // fault indication from the drive core
   input wire fault_s drive_fault,
   // feedback and state
   output logic stop_monitor_feedback,
   output logic hardwired_baseblock,
   output logic motor_enable,
   // fault outputs toward the controller
   output fault_s fault_out,
   output logic input_timing_alarm,
   // operator monitoring
   output logic [1:0] safety_input_monitor,
   output disp_e display_code
);
   localparam int SW = $clog2(SKEW_CYCLES + 1);
   // two redundant channels; a third would need a wider monitor field
   localparam int CHANNELS = 2;

   // pair decodes shared by several groups
   // both channels filtered on: normal operation
   function automatic logic both_on(input logic a, input logic b);
      return a && b;
   endfunction : both_on

   // both channels filtered off: a complete two-channel stop
   function automatic logic both_off(input logic a, input logic b);
      return !a && !b;
   endfunction : both_off

   // channel 0 is request a, channel 1 is request b
   logic [CHANNELS-1:0] raw_req;
   logic [CHANNELS-1:0] on_ch;
   logic on_a;
   logic on_b;

   // feedback, baseblock and enable group
   logic fb_reg, fb_next;
   logic bb_reg, bb_next;
   logic en_reg, en_next;

   // monitor group
   logic [1:0] mon_reg, mon_next;

   // single-channel timing group
   logic [SW-1:0] skew_reg, skew_next;
   logic alm_reg, alm_next;

   // fault muting group
   fault_s flt_reg, flt_next;

   // operator display group
   disp_e disp_reg, disp_next;

   assign raw_req = {safe_stop_req_b, safe_stop_req_a};

   // [RULE10] one glitch filter per channel
   // [RULE12] synchroniser inside each filter
   // one filter per channel keeps the two paths independent
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      stop_input_filter #(
         .GLITCH_CYCLES(GLITCH_CYCLES)
      ) u_filt (
         .clk(clk),
         .rstn(rstn),
         .raw_in(raw_req[ch]),
         .filt_out(on_ch[ch])
      );
   end

   // an off edge lags by the filter time, an on edge does not,
   // so a restart is never slowed by the glitch rejection
   assign on_a = on_ch[0];
   assign on_b = on_ch[1];

   // feedback, baseblock and enable
   // after reset the filters read off, so feedback shows a proven stop
   // for a few cycles until the lines propagate
   always_comb begin
      // [RULE9] either off baseblocks
      bb_next = !both_on(on_a, on_b);
      // [RULE2] both off drives feedback
      // [RULE3] the 0.5 ms off filter plus a few cycles, well under 20 ms
      fb_next = both_off(on_a, on_b);
      // [RULE4] motor held off
      en_next = both_on(on_a, on_b);
   end

   // [RULE12] clear on reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         fb_reg <= 1'b0;
         bb_reg <= 1'b0;
         en_reg <= 1'b0;
      end else begin
         fb_reg <= fb_next;
         bb_reg <= bb_next;
         en_reg <= en_next;
      end
   end

   // monitor
   always_comb begin
      // [RULE5] input states to monitor
      // bits follow the filtered lines, not the raw pins
      mon_next = '0;
      mon_next[`MON_BIT_A] = on_a;
      mon_next[`MON_BIT_B] = on_b;
   end

   // [RULE12] clear on reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         mon_reg <= '0;
      end else begin
         mon_reg <= mon_next;
      end
   end

   // single-channel timing
   // [RULE11] count single-channel time
   always_comb begin
      skew_next = '0;
      alm_next = alm_reg;
      if (on_a == on_b) begin
         // pair agrees again: restart the count
         skew_next = '0;
      end else if (skew_reg >= SW'(SKEW_CYCLES - 1)) begin
         // hold the count: a 10 s counter must not wrap
         alm_next = 1'b1;
         skew_next = skew_reg;
      end else begin
         skew_next = skew_reg + SW'(1);
      end
   end

   // alarm latches until reset: a broken wire must not self-clear
   // [RULE12] clear on reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         skew_reg <= '0;
         alm_reg <= 1'b0;
      end else begin
         skew_reg <= skew_next;
         alm_reg <= alm_next;
      end
   end

   // fault muting
   // [RULE1] mute faults in baseblock
   // same decode as the baseblock flag, so both registers change on one edge
   always_comb begin
      if (both_on(on_a, on_b)) begin
         flt_next = drive_fault;
      end else begin
         // a core fault during baseblock is dropped, not held
         flt_next = '0;
      end
   end

   // [RULE12] clear on reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flt_reg <= '0;
      end else begin
         flt_reg <= flt_next;
      end
   end

   // operator display
   // [RULE4] hard-stop display
   // hard stop outranks the alarm: the operator sees the stop first
   // codes live in the package enum
   always_comb begin
      if (both_off(on_a, on_b)) begin
         disp_next = disp_hard_stop;
      end else if (alm_next) begin
         disp_next = disp_alarm;
      end else begin
         disp_next = disp_run;
      end
   end

   // [RULE12] clear on reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         disp_reg <= disp_run;
      end else begin
         disp_reg <= disp_next;
      end
   end

   // every output is a register, never a gate
   assign stop_monitor_feedback = fb_reg;
   assign hardwired_baseblock = bb_reg;
   assign motor_enable = en_reg;
   assign fault_out = flt_reg;
   assign input_timing_alarm = alm_reg;
   assign safety_input_monitor = mon_reg;
   assign display_code = disp_reg;
endmodule : safe_stop_feedback_monitor

/* File: tb/safe_stop_asserts.sv */
module safe_stop_asserts
   import safe_stop_pkg::*;
#(
   parameter int unsigned GLITCH_CYCLES = 8,
   parameter longint unsigned SKEW_CYCLES = 50
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // watched pins
   input wire logic safe_stop_req_a,
   input wire logic safe_stop_req_b,
   input wire logic stop_monitor_feedback,
   input wire logic hardwired_baseblock,
   input wire logic motor_enable,
   input wire fault_s fault_out,
   input wire logic input_timing_alarm,
   input wire logic [1:0] safety_input_monitor,
   input wire disp_e display_code
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   chk_fault_mute: assert property (hardwired_baseblock |-> fault_out == 4'h0)
      else $error("fault output not muted");
   chk_fb_both: assert property ($past(rstn, 2) |-> stop_monitor_feedback == (safety_input_monitor == 2'h0))
      else $error("feedback disagrees with inputs");
   chk_fb_bound: assert property (
      $fell(safe_stop_req_a || safe_stop_req_b) ##1 (!safe_stop_req_a && !safe_stop_req_b) [*8]
      |-> ##[1:8] stop_monitor_feedback) else $error("feedback late");
   chk_hard_stop: assert property (stop_monitor_feedback |-> display_code == disp_hard_stop && !motor_enable)
      else $error("hard stop not shown");
   chk_mon_follow: assert property ($rose(safe_stop_req_b) |-> ##[3:5] safety_input_monitor[1])
      else $error("monitor bit 1 stale");
   chk_bb_either: assert property ($past(rstn, 2) |-> hardwired_baseblock == (safety_input_monitor != 2'h3))
      else $error("baseblock wrong");
   chk_glitch_len: assert property (
      $fell(safety_input_monitor[0]) |-> !$past(safe_stop_req_a, 5) && !$past(safe_stop_req_a, 10))
      else $error("short off pulse taken");
   chk_alarm_hold: assert property (
      input_timing_alarm |=> input_timing_alarm && (stop_monitor_feedback || display_code == disp_alarm))
      else $error("alarm dropped");
endmodule : safe_stop_asserts
bind safe_stop_feedback_monitor safe_stop_asserts #(.GLITCH_CYCLES(GLITCH_CYCLES), .SKEW_CYCLES(SKEW_CYCLES))
   u_asserts (.clk, .rstn, .safe_stop_req_a, .safe_stop_req_b, .stop_monitor_feedback, .hardwired_baseblock,
   .motor_enable, .fault_out, .input_timing_alarm, .safety_input_monitor, .display_code);

/* File: tb/safety_unit_model.sv */
module safety_unit_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // guard, injected faults and feedback
   input wire logic guard_open,
   input wire logic stick_b,
   input wire logic drop_a,
   input wire logic fb,
   // stop requests and restart permission
   output logic req_a,
   output logic req_b,
   output logic restart_ok
);
   timeunit 1ns;
   timeprecision 100ps;
   logic open_reg;
   logic open_next;
   always_comb begin
      open_next = guard_open || (open_reg && !fb);
   end
   // starts open so feedback is proven at power-up
   always_ff @(posedge clk) begin
      open_reg <= rstn ? open_next : 1'b1;
   end
   assign req_a = !open_reg && !drop_a;
   assign req_b = !open_reg || stick_b;
   assign restart_ok = !open_reg;
endmodule : safety_unit_model

/* File: tb/tb_top.sv */
module tb_top
   import safe_stop_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic guard_open = 1'b0;
   logic stick_b = 1'b0;
   logic drop_a = 1'b0;
   fault_s drive_fault = 4'hA;
   logic req_a, req_b, restart_ok, fb, bb, men, alarm;
   logic [1:0] mon;
   disp_e disp;
   fault_s fout;
   logic [11:0] obs;
   int errors = 0;
   int checks = 0;
   int cycles = 0;
   assign obs = {mon, fb, bb, men, alarm, disp, fout};
   always #2 clk = ~clk;
   safe_stop_feedback_monitor #(.GLITCH_CYCLES(8), .SKEW_CYCLES(50)) u_dut (.clk(clk), .rstn(rstn),
      .safe_stop_req_a(req_a), .safe_stop_req_b(req_b), .drive_fault(drive_fault), .stop_monitor_feedback(fb),
      .hardwired_baseblock(bb), .motor_enable(men), .fault_out(fout), .input_timing_alarm(alarm),
      .safety_input_monitor(mon), .display_code(disp));
   safety_unit_model u_unit (.clk(clk), .rstn(rstn), .guard_open(guard_open), .stick_b(stick_b),
      .drop_a(drop_a), .fb(fb), .req_a(req_a), .req_b(req_b), .restart_ok(restart_ok));
   task report_and_stop;
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h", $time, got);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         errors++;
         $display("unexpected at %0t: timeout", $time);
         report_and_stop();
      end
   end
   initial begin
      tick(16);
      rstn <= 1'b1;
      tick(30);
      chk(obs, {2'b11, 4'b0010, disp_run, drive_fault});
      drop_a <= 1'b1;
      tick(7);
      drop_a <= 1'b0;
      tick(30);
      chk(obs, {2'b11, 4'b0010, disp_run, drive_fault});
      drop_a <= 1'b1;
      tick(8);
      drop_a <= 1'b0;
      tick(4);
      chk(obs, {2'b10, 4'b0100, disp_run, 4'h0});
      tick(26);
      guard_open <= 1'b1;
      tick(30);
      chk(obs, {2'b00, 4'b1100, disp_hard_stop, 4'h0});
      guard_open <= 1'b0;
      tick(30);
      chk(obs, {2'b11, 4'b0010, disp_run, drive_fault});
      stick_b <= 1'b1;
      guard_open <= 1'b1;
      tick(30);
      chk(obs, {2'b10, 4'b0100, disp_run, 4'h0});
      guard_open <= 1'b0;
      tick(50);
      chk({11'h0, restart_ok}, 12'h0);
      chk(obs, {2'b10, 4'b0101, disp_alarm, 4'h0});
      stick_b <= 1'b0;
      rstn <= 1'b0;
      tick(16);
      chk(obs, 12'h0);
      rstn <= 1'b1;
      tick(30);
      chk(obs, {2'b11, 4'b0010, disp_run, drive_fault});
      report_and_stop();
   end
endmodule : tb_top
